// file: common/an_status_pkg.sv
/*
 * package for the negotiation status register bank: offsets, field positions,
 * reset values and the carrier types shared by the design.
 * assumes a 16-bit management register space indexed by a 5-bit address.
 */
package an_status_pkg;

    localparam int          ADDR_W                 = 5;
    localparam int          DATA_W                 = 16;
    localparam logic [4:0]  PARTNER_PAGE_ADDR      = 5'h05;
    localparam logic [4:0]  EXPANSION_ADDR         = 5'h06;

    localparam int          PG_FURTHER_BIT         = 15;
    localparam int          PG_ACK_BIT             = 14;
    localparam int          PG_MESSAGE_BIT         = 13;
    localparam int          PG_COMPLY_BIT          = 12;
    localparam int          PG_TOGGLE_BIT          = 11;
    localparam int          PG_CODE_MSB            = 10;

    localparam int          EX_FAULT_BIT           = 4;
    localparam int          EX_PARTNER_EXTRA_BIT   = 3;
    localparam int          EX_LOCAL_EXTRA_BIT     = 2;
    localparam int          EX_PAGE_RX_BIT         = 1;
    localparam int          EX_PARTNER_NEG_BIT     = 0;

    localparam logic [10:0] CODE_RESET             = 11'h000;
    localparam logic [15:0] READ_ZERO              = 16'h0000;
    localparam logic        LOCAL_EXTRA_VALUE      = 1'b1;

    // fields captured from a received next page
    typedef struct packed {
        logic        further_page_request;
        logic        ack;
        logic        message_page_flag;
        logic        comply_ability_flag;
        logic        toggle;
        logic [10:0] code;
    } page_word_t;

    // status levels from the negotiation logic
    typedef struct packed {
        logic parallel_detect_fault;
        logic partner_extra_page_capable;
        logic partner_negotiation_capable;
    } neg_status_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mgmt_req_t;

endpackage : an_status_pkg

// file: core/autoneg_partner_page_status.sv
/*
 * status register bank for the partner next page view and the expansion
 * status register of the negotiation function.
 * assumes the negotiation logic runs on clk_i and presents a one-cycle
 * page_valid_i pulse with the received page word; status inputs are levels
 * from the same clock domain.
 */
// Our own choice: strobed register access.
`timescale 1ns/10ps
// How it works
// - ack bit follows received pages, hardware only
// - bit 13 shows message page flag
// - bit 12 shows partner comply ability
// - bit 11 shows received toggle value
// - bits 10:0 hold partner page code
// - expansion bits 15:5 read zero
// - expansion bit 4 shows parallel detect fault
// - expansion bit 3 partner next page able
// - expansion bit 2 constant one
// - page received flag, clear on read
// - expansion bit 0 partner negotiation able
// - partner page view at address 05h
// - bit 15 shows further page request
module autoneg_partner_page_status
    import an_status_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
)
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic [ADDR_WIDTH-1:0] addr_i,
    input  wire logic [DATA_WIDTH-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [DATA_WIDTH-1:0] rdata_o,
    input  wire logic                  page_valid_i,
    input  wire page_word_t            page_word_i,
    input  wire neg_status_t           neg_status_i
);

    ////////////////////////////////////////////////////////////////////////////
    // the carrier structs fix both widths, so no other width can be served
    if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin : gen_width_check
        $error("register bus widths must match the package carriers");
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        page_word_t  page;
        neg_status_t stat;
        logic        page_rx;
        logic [15:0] rdata;
    } state_t;

    state_t      cur;
    state_t      next_cur;
    mgmt_req_t   req;
    logic [15:0] page_view;
    logic [15:0] exp_view;
    logic        rd_exp;
    logic        rd_page;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    ////////////////////////////////////////////////////////////////////////////
    // register views
    always_comb begin
        page_view                        = READ_ZERO;
        page_view[PG_FURTHER_BIT]        = cur.page.further_page_request;
        page_view[PG_ACK_BIT]            = cur.page.ack;
        page_view[PG_MESSAGE_BIT]        = cur.page.message_page_flag;
        page_view[PG_COMPLY_BIT]         = cur.page.comply_ability_flag;
        page_view[PG_TOGGLE_BIT]         = cur.page.toggle;
        page_view[PG_CODE_MSB:0]         = cur.page.code;
        exp_view                         = READ_ZERO;
        exp_view[EX_FAULT_BIT]           = cur.stat.parallel_detect_fault;
        exp_view[EX_PARTNER_EXTRA_BIT]   = cur.stat.partner_extra_page_capable;
        exp_view[EX_LOCAL_EXTRA_BIT]     = LOCAL_EXTRA_VALUE;
        exp_view[EX_PAGE_RX_BIT]         = cur.page_rx;
        exp_view[EX_PARTNER_NEG_BIT]     = cur.stat.partner_negotiation_capable;
    end

    assign rd_exp = req.rd && (req.addr == EXPANSION_ADDR);
    assign rd_page = req.rd && (req.addr == PARTNER_PAGE_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // next state; writes are ignored everywhere
    always_comb begin
        next_cur      = cur;
        next_cur.stat = neg_status_i;
        if (page_valid_i) begin
            next_cur.page = page_word_i;
        end
        if (page_valid_i) begin
            next_cur.page_rx = 1'b1;
        end else if (rd_exp) begin
            next_cur.page_rx = 1'b0;
        end
        next_cur.rdata = READ_ZERO;
        if (req.rd) begin
            case (req.addr)
                PARTNER_PAGE_ADDR: begin
                    next_cur.rdata = page_view;
                end
                EXPANSION_ADDR: begin
                    next_cur.rdata = exp_view;
                end
                default: begin
                    next_cur.rdata = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cur.page.further_page_request <= 1'b0;
            cur.page.ack                  <= 1'b0;
            cur.page.message_page_flag    <= 1'b0;
            cur.page.comply_ability_flag  <= 1'b0;
            cur.page.toggle               <= 1'b0;
            cur.page.code                 <= CODE_RESET;
            cur.stat                      <= '0;
            cur.page_rx                   <= 1'b0;
            cur.rdata                     <= READ_ZERO;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_o = cur.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_page_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        page_valid_i |=> cur.page_rx)
        else $error("page did not set received flag");

    chk_read_clears_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_exp && !page_valid_i) |=> !cur.page_rx)
        else $error("read did not clear received flag");

    chk_read_old_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp |=> rdata_o[EX_PAGE_RX_BIT] == $past(cur.page_rx))
        else $error("read did not return old flag");

    chk_local_extra_one: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp |=> rdata_o[EX_LOCAL_EXTRA_BIT])
        else $error("local next page bit not one");

    chk_exp_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp |=> rdata_o[15:5] == 11'h000)
        else $error("expansion upper bits not zero");

    chk_fault_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        !reset_i ##1 rd_exp |=> rdata_o[EX_FAULT_BIT] == $past(neg_status_i.parallel_detect_fault, 2))
        else $error("fault bit wrong");

    chk_page_view_word: assert property (@(posedge clk_i) disable iff (reset_i)
        (page_valid_i ##1 (req.rd && req.addr == PARTNER_PAGE_ADDR && !page_valid_i))
        |=> rdata_o == $past(page_word_i, 2))
        else $error("partner page view wrong");

    chk_page_held: assert property (@(posedge clk_i) disable iff (reset_i)
        !page_valid_i |=> cur.page == $past(cur.page))
        else $error("page changed without receive");

    chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        (req.rd && req.addr != PARTNER_PAGE_ADDR && req.addr != EXPANSION_ADDR) |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////////////////
    // reset checks
    chk_reset_page_zero: assert property (@(posedge clk_i)
        reset_i
        |=> cur.page == READ_ZERO)
        else $error("page fields not cleared by reset");

    chk_reset_flag_zero: assert property (@(posedge clk_i)
        reset_i
        |=> !cur.page_rx)
        else $error("received flag not cleared by reset");

    chk_reset_read_zero: assert property (@(posedge clk_i)
        reset_i
        |=> rdata_o == READ_ZERO)
        else $error("read data not cleared by reset");

    chk_reset_stat_zero: assert property (@(posedge clk_i)
        reset_i
        |=> cur.stat == '0)
        else $error("status levels not cleared by reset");

    ////////////////////////////////////////////////////////////////////////////
    // register view checks
    chk_idle_read_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        !req.rd
        |=> rdata_o == READ_ZERO)
        else $error("read data not zero without read");

    chk_further_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_FURTHER_BIT] == $past(cur.page.further_page_request))
        else $error("further page bit wrong");

    chk_ack_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_ACK_BIT] == $past(cur.page.ack))
        else $error("acknowledge bit wrong");

    chk_message_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_MESSAGE_BIT] == $past(cur.page.message_page_flag))
        else $error("message page bit wrong");

    chk_comply_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_COMPLY_BIT] == $past(cur.page.comply_ability_flag))
        else $error("comply bit wrong");

    chk_toggle_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_TOGGLE_BIT] == $past(cur.page.toggle))
        else $error("toggle bit wrong");

    chk_code_field: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_page
        |=> rdata_o[PG_CODE_MSB:0] == $past(cur.page.code))
        else $error("page code wrong");

    chk_fault_bit_view: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp
        |=> rdata_o[EX_FAULT_BIT] == $past(cur.stat.parallel_detect_fault))
        else $error("fault bit view wrong");

    chk_partner_extra_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp
        |=> rdata_o[EX_PARTNER_EXTRA_BIT] == $past(cur.stat.partner_extra_page_capable))
        else $error("partner next page bit wrong");

    chk_partner_neg_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_exp
        |=> rdata_o[EX_PARTNER_NEG_BIT] == $past(cur.stat.partner_negotiation_capable))
        else $error("partner negotiation bit wrong");

    chk_stat_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        !reset_i
        |=> cur.stat == $past(neg_status_i))
        else $error("status levels not registered");

    ////////////////////////////////////////////////////////////////////////////
    // received flag and page field checks
    chk_write_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
        (req.wr && !page_valid_i && !rd_exp)
        |=> (cur.page == $past(cur.page) && cur.page_rx == $past(cur.page_rx)))
        else $error("write changed state");

    chk_flag_holds: assert property (@(posedge clk_i) disable iff (reset_i)
        (!page_valid_i && !rd_exp)
        |=> cur.page_rx == $past(cur.page_rx))
        else $error("received flag changed without cause");

    chk_set_beats_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        (page_valid_i && rd_exp)
        |=> (cur.page_rx && rdata_o[EX_PAGE_RX_BIT] == $past(cur.page_rx)))
        else $error("clearing read beat arriving page");

    chk_page_capture: assert property (@(posedge clk_i) disable iff (reset_i)
        page_valid_i
        |=> cur.page == $past(page_word_i))
        else $error("received page not captured");

    chk_page_read_keeps_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_page && !page_valid_i)
        |=> cur.page_rx == $past(cur.page_rx))
        else $error("page view read touched flag");

    chk_unmapped_keeps_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        (req.rd && !rd_page && !rd_exp && !page_valid_i)
        |=> cur.page_rx == $past(cur.page_rx))
        else $error("unmapped read touched flag");

    chk_read_no_page_change: assert property (@(posedge clk_i) disable iff (reset_i)
        (req.rd && !page_valid_i)
        |=> cur.page == $past(cur.page))
        else $error("read changed page fields");

    chk_flag_visible: assert property (@(posedge clk_i) disable iff (reset_i)
        (page_valid_i ##1 rd_exp)
        |=> rdata_o[EX_PAGE_RX_BIT])
        else $error("received flag not visible");

    chk_flag_rise_by_page: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(cur.page_rx)
        |-> $past(page_valid_i))
        else $error("received flag set without page");

    chk_flag_fall_by_read: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(cur.page_rx)
        |-> ($past(rd_exp) || $past(reset_i)))
        else $error("received flag cleared without read");

endmodule : autoneg_partner_page_status

// file: testbench/tb.sv
/*
 * bench for the negotiation status register bank: register reads, writes,
 * received pages and status levels, each scenario in its own task, all judged together at the end.
 * assumes one 125 MHz clock and the one-cycle read latency of the bank.
 */
`timescale 1ns/10ps
module tb;
    import an_status_pkg::*;
    logic        clk_i        = 1'b0;
    logic        reset_i      = 1'b1;
    logic [4:0]  addr_i       = 5'h00;
    logic [15:0] wdata_i      = 16'h0000;
    logic        wr_i         = 1'b0;
    logic        rd_i         = 1'b0;
    logic        page_valid_i = 1'b0;
    page_word_t  page_word_i  = '0;
    neg_status_t neg_status_i = '0;
    logic [15:0] rdata_o;
    int          num_errors   = 0;
    int          cmp_count    = 0;
    always #4 clk_i = ~clk_i;
    autoneg_partner_page_status dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .page_valid_i(page_valid_i),
        .page_word_i(page_word_i), .neg_status_i(neg_status_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        cmp_count++;
        if (seen !== expected) begin
            num_errors++;
            $display("wrong value at %0t: read %h, wanted %h", $time, seen, expected);
        end
    endtask : check
    // read with optional page arriving at the same edge
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic pv = 1'b0, input logic [15:0] w = 0);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        page_valid_i <= pv;
        page_word_i <= page_word_t'(w);
        @(posedge clk_i);
        rd_i <= 1'b0;
        page_valid_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask : rd
    task automatic pg(input logic [15:0] w);
        @(posedge clk_i);
        page_valid_i <= 1'b1;
        page_word_i <= page_word_t'(w);
        @(posedge clk_i);
        page_valid_i <= 1'b0;
    endtask : pg
    // page followed at once by a read
    task automatic pg_rd(input logic [15:0] w, input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        page_valid_i <= 1'b1;
        page_word_i <= page_word_t'(w);
        @(posedge clk_i);
        page_valid_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask : pg_rd
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    ////////////////////////////////////////////////////////////////////////////
    task automatic reset_values;
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        rd(5'h07, 16'h0000);
    endtask : reset_values
    task automatic write_ignored;
        wr(5'h05, 16'hbfff);
        wr(5'h06, 16'hffff);
        rd(5'h06, 16'h0004);
        rd(5'h05, 16'h0000);
    endtask : write_ignored
    task automatic page_capture;
        pg(16'hd555);
        rd(5'h05, 16'hd555);
        rd(5'h06, 16'h0006);
        rd(5'h06, 16'h0004);
        pg(16'h2aaa);
        rd(5'h05, 16'h2aaa);
    endtask : page_capture
    task automatic clear_race;
        rd(5'h06, 16'h0006, 1'b1, 16'h0001);
        rd(5'h06, 16'h0006);
        rd(5'h06, 16'h0004);
        rd(5'h06, 16'h0004, 1'b1, 16'h0003);
        rd(5'h06, 16'h0006);
        rd(5'h06, 16'h0004);
        rd(5'h05, 16'h0003);
    endtask : clear_race
    task automatic page_then_read;
        pg_rd(16'h8001, 5'h05, 16'h8001);
        pg_rd(16'h4002, 5'h06, 16'h0006);
        rd(5'h05, 16'h4002);
    endtask : page_then_read
    task automatic status_levels;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            neg_status_i <= neg_status_t'(i[2:0]);
            rd(5'h06, {11'h000, i[2], i[1], 1'b1, 1'b0, i[0]});
        end
    endtask : status_levels
    task automatic mid_reset;
        pg(16'hffff);
        @(posedge clk_i);
        reset_i <= 1'b1;
        neg_status_i <= '0;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
    endtask : mid_reset
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        reset_values();
        write_ignored();
        page_capture();
        clear_race();
        page_then_read();
        status_levels();
        mid_reset();
        conclude();
    end
endmodule : tb
